// *** pcs_core.sv ***
// program counter, high holding latch and circular return stack with axi4-lite register access
`timescale 1ns/1ps
module pcs_core #(
   parameter int STACK_DEPTH = pcs_pkg::PCS_STACK_DEPTH,
   parameter bit PAGE_BITS_USED = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   // decoder and interrupt side
   input wire pcs_pkg::pcs_cmd_t cmd,
   input wire pcs_pkg::pcs_low_wr_t core_low_wr,
   output logic [pcs_pkg::PCS_PC_W-1:0] pc,
   output logic [pcs_pkg::PCS_HIGH_W-1:0] pc_high_holding_latch,
   // axi4-lite slave
   input wire logic [pcs_pkg::PCS_AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [pcs_pkg::PCS_AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import pcs_pkg::*;

   // pointer width; a depth that is not a power of two would break the silent wrap
   localparam int PTR_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
   localparam logic [PTR_W-1:0] PTR_ZERO = PTR_W'(0);

   // stack storage, deliberately not mapped on the bus
   logic [PCS_PC_W-1:0] stack [STACK_DEPTH];
   logic [PTR_W-1:0] stack_ptr;

   // write channel holding state
   logic aw_held;
   logic [PCS_AXI_ADDR_W-1:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // bus decode and register strobes
   logic wr_commit;
   logic wr_low_hit;
   logic wr_latch_hit;
   logic wr_ok;
   logic sw_low_wr;
   logic sw_latch_wr;
   logic rd_take;
   logic [PCS_AXI_ADDR_W-1:0] rd_word;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   // sequencing datapath
   logic [PCS_PC_W-1:0] next_pc;
   logic [PCS_PC_W-1:0] pc_inc;
   logic [PCS_PC_W-1:0] push_value;
   logic [PCS_PC_W-1:0] pop_value;
   logic [PCS_PC_W-1:0] jump_value;
   logic [PCS_PAGE_W-1:0] page_bits;
   logic [PTR_W-1:0] pop_ptr;
   logic do_push;
   logic do_pop;

   // axi handshakes: one outstanding write and read at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_commit = aw_held && w_held && !s_axi_bvalid;
   assign rd_take = s_axi_arvalid && s_axi_arready;

   // address decode on the held write address; a misaligned offset misses every item
   always_comb begin
      wr_low_hit = 1'b0;
      wr_latch_hit = 1'b0;
      wr_ok = 1'b1;
      case (aw_addr)
         PCS_OFF_PC_LOW_BYTE: begin
            wr_low_hit = 1'b1;
         end
         PCS_OFF_PC_HIGH_HOLDING_LATCH: begin
            wr_latch_hit = 1'b1;
         end
         PCS_OFF_PC_VALUE: begin
            wr_ok = 1'b1; // read-only view, write accepted and dropped
         end
         default: begin
            wr_ok = 1'b0;
         end
      endcase
   end
   // only byte lane 0 carries data; a write with lane 0 off changes nothing
   assign sw_low_wr = wr_commit && wr_low_hit && w_strb[0];
   assign sw_latch_wr = wr_commit && wr_latch_hit && w_strb[0];

   // write address channel capture
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= PCS_OFF_PC_LOW_BYTE;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_commit) begin
         aw_held <= 1'b0;
      end
   end

   // write data channel capture, independent of the address channel
   always_ff @(posedge clk) begin
      if (rst) begin
         w_held <= 1'b0;
         w_data <= PCS_DATA_ZERO;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_commit) begin
         w_held <= 1'b0;
      end
   end

   // write response; the read-only pc view answers okay and ignores data
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PCS_RESP_OKAY;
      end else if (wr_commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? PCS_RESP_OKAY : PCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel; stack pointer and entries are never visible here
   assign rd_word = s_axi_araddr;

   // read data selection; anything off the map answers zero with an error
   always_comb begin
      next_rdata = PCS_DATA_ZERO;
      next_rresp = PCS_RESP_OKAY;
      case (rd_word)
         PCS_OFF_PC_LOW_BYTE: begin
            next_rdata = {24'h00_0000, pc[PCS_LOW_W-1:0]};
         end
         PCS_OFF_PC_HIGH_HOLDING_LATCH: begin
            next_rdata = {27'h000_0000, pc_high_holding_latch};
         end
         PCS_OFF_PC_VALUE: begin
            next_rdata = {19'h0_0000, pc};
         end
         default: begin
            next_rdata = PCS_DATA_ZERO;
            next_rresp = PCS_RESP_SLVERR;
         end
      endcase
   end

   // read response register; data is captured once and held until rready
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= PCS_DATA_ZERO;
         s_axi_rresp <= PCS_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // the latch has one writer, software; stack traffic never touches it
   always_ff @(posedge clk) begin
      if (rst) begin
         pc_high_holding_latch <= PCS_LATCH_RESET;
      end else if (sw_latch_wr) begin
         // page bits are kept as storage so software reads back what it wrote
         pc_high_holding_latch <= w_data[PCS_HIGH_W-1:0];
      end
   end

   // page bits above the 11-bit target; masked off unless PAGE_BITS_USED is set
   always_comb begin
      if (PAGE_BITS_USED) begin
         page_bits = pc_high_holding_latch[PCS_PAGE_LSB +: PCS_PAGE_W];
      end else begin
         page_bits = PCS_PAGE_ZERO;
      end
   end
   assign jump_value = {page_bits, cmd.target};
   assign pc_inc = pc + PCS_PC_ONE;
   assign pop_ptr = stack_ptr - PTR_ONE;
   assign pop_value = stack[pop_ptr];

   // a call returns past itself; an interrupt resumes the instruction it preempted
   always_comb begin
      if (cmd.op == PCS_OP_CALL) begin
         push_value = pc_inc;
      end else begin
         push_value = pc;
      end
   end

   // sequencing decode, computed each cycle from the decoder command
   always_comb begin
      do_push = 1'b0;
      do_pop = 1'b0;
      next_pc = pc;
      case (cmd.op)
         PCS_OP_HOLD: begin
            next_pc = pc;
         end
         PCS_OP_ADVANCE: begin
            next_pc = pc_inc;
         end
         PCS_OP_JUMP: begin
            next_pc = jump_value;
         end
         PCS_OP_CALL: begin
            do_push = 1'b1;
            next_pc = jump_value;
         end
         PCS_OP_RETURN, PCS_OP_EXIT_WITH_LITERAL, PCS_OP_INTERRUPT_EXIT: begin
            do_pop = 1'b1;
            next_pc = pop_value;
         end
         PCS_OP_INT_ACK: begin
            do_push = 1'b1;
            next_pc = PCS_INT_VECTOR;
         end
         default: begin
            next_pc = pc;
         end
      endcase
      // a core write to the low byte takes the upper bits from the latch, no carry
      if (core_low_wr.wr) begin
         next_pc = {pc_high_holding_latch, core_low_wr.data};
      end
      // software wins over the core so a bus write is never silently lost
      if (sw_low_wr) begin
         next_pc = {pc_high_holding_latch, w_data[PCS_LOW_W-1:0]};
      end
   end

   // program counter register
   always_ff @(posedge clk) begin
      if (rst) begin
         pc <= PCS_RESET_VECTOR;
      end else begin
         pc <= next_pc;
      end
   end

   // stack pointer wraps modulo the depth; overflow and underflow go unreported
   always_ff @(posedge clk) begin
      if (rst) begin
         stack_ptr <= PTR_ZERO;
      end else if (do_push) begin
         stack_ptr <= stack_ptr + PTR_ONE;
      end else if (do_pop) begin
         stack_ptr <= pop_ptr;
      end
   end

   // stack entries; a push past the depth overwrites the oldest slot
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack[i] <= PCS_RESET_VECTOR;
         end
      end else if (do_push) begin
         stack[stack_ptr] <= push_value;
      end
   end
endmodule

// *** pcs_core_monitor.sv ***
// port checker for the program counter and call stack
`timescale 1ns/1ps
module pcs_core_monitor #(
   parameter int STACK_DEPTH = 8,
   parameter bit PAGE_BITS_USED = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire pcs_pkg::pcs_cmd_t cmd,
   input wire pcs_pkg::pcs_low_wr_t core_low_wr,
   input wire logic [pcs_pkg::PCS_PC_W-1:0] pc,
   input wire logic [pcs_pkg::PCS_HIGH_W-1:0] pc_high_holding_latch,
   input wire logic s_axi_bvalid,
   input wire logic [pcs_pkg::PCS_AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata
);
   import pcs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a bus commit shows as bvalid rising and may override the command
   wire quiet = !core_low_wr.wr;
   property p_branch; (quiet && cmd.op inside {PCS_OP_JUMP, PCS_OP_CALL}) |=> $rose(s_axi_bvalid) ||
      pc == {(PAGE_BITS_USED ? $past(pc_high_holding_latch[PCS_PAGE_LSB +: PCS_PAGE_W]) : PCS_PAGE_ZERO),
      $past(cmd.target)}; endproperty
   a_branch: assert property (p_branch) else $error("branch target wrong");
   property p_advance; (quiet && cmd.op == PCS_OP_ADVANCE) |=> $rose(s_axi_bvalid) || pc == $past(pc) + PCS_PC_ONE; endproperty
   a_advance: assert property (p_advance) else $error("advance wrong");
   property p_hold; (quiet && cmd.op == PCS_OP_HOLD) |=> $rose(s_axi_bvalid) || $stable(pc); endproperty
   a_hold: assert property (p_hold) else $error("pc moved on hold");
   property p_low; core_low_wr.wr |=> $rose(s_axi_bvalid) || pc == {$past(pc_high_holding_latch), $past(core_low_wr.data)}; endproperty
   a_low: assert property (p_low) else $error("low byte load wrong");
   property p_vector; (quiet && cmd.op == PCS_OP_INT_ACK) |=> $rose(s_axi_bvalid) || pc == PCS_INT_VECTOR; endproperty
   a_vector: assert property (p_vector) else $error("interrupt vector wrong");
   property p_latch; !$rose(s_axi_bvalid) |-> $stable(pc_high_holding_latch); endproperty
   a_latch: assert property (p_latch) else $error("latch changed without a write");
   property p_read; (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid; endproperty
   a_read: assert property (p_read) else $error("read answer late");
   property p_view; (s_axi_arvalid && s_axi_arready && s_axi_araddr == PCS_OFF_PC_VALUE) |=> s_axi_rdata == {19'h0_0000, $past(pc)}; endproperty
   a_view: assert property (p_view) else $error("pc view wrong");
endmodule
bind pcs_core pcs_core_monitor #(.STACK_DEPTH(STACK_DEPTH), .PAGE_BITS_USED(PAGE_BITS_USED)) u_monitor (.clk(clk),
   .rst(rst), .cmd(cmd),
   .core_low_wr(core_low_wr), .pc(pc), .pc_high_holding_latch(pc_high_holding_latch), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata));

// *** pcs_core_tb.sv ***
// self-checking bench for the program counter and call stack
`timescale 1ns/1ps
module pcs_core_tb;
   import pcs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pcs_op_t op = PCS_OP_HOLD;
   logic [10:0] tgt = 11'h000;
   logic lw = 1'b0;
   logic [7:0] ld = 8'h00, awaddr = 8'h00, araddr = 8'h00, b;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   pcs_cmd_t cmd;
   pcs_low_wr_t core_low_wr;
   logic [12:0] pc, exp_pc, stk [8];
   logic [4:0] latch, exp_latch;
   int ptr = 0;
   int bad_count = 0;
   int total_checks = 0;
   always #2 clk = ~clk;
   pcs_decoder_model far (.op(op), .target(tgt), .low_wr(lw), .low_data(ld), .cmd(cmd), .core_low_wr(core_low_wr));
   pcs_core dut (.clk(clk), .rst(rst), .cmd(cmd), .core_low_wr(core_low_wr), .pc(pc), .pc_high_holding_latch(latch),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      total_checks++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // address and data offered together, each dropped once taken; bready held until the answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // no cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // expected counter and circular stack; wrapping is silent by design
   function automatic void model(input pcs_op_t o, input logic [10:0] t);
      case (o)
         PCS_OP_HOLD: ;
         PCS_OP_ADVANCE: exp_pc = exp_pc + 13'h0001;
         PCS_OP_JUMP: exp_pc = {2'h0, t};
         PCS_OP_CALL, PCS_OP_INT_ACK: begin
            stk[ptr] = (o == PCS_OP_CALL) ? exp_pc + 13'h0001 : exp_pc;
            ptr = (ptr + 1) % 8;
            exp_pc = (o == PCS_OP_CALL) ? {2'h0, t} : PCS_INT_VECTOR;
         end
         default: begin
            ptr = (ptr + 7) % 8;
            exp_pc = stk[ptr];
         end
      endcase
   endfunction
   // one command then a quiet cycle, compared once the edge has landed
   task automatic step(input pcs_op_t o, input logic [10:0] t);
      @(posedge clk);
      op <= o;
      tgt <= t;
      @(posedge clk);
      op <= PCS_OP_HOLD;
      tgt <= ~t;
      model(o, t);
      #1;
      check("pc", 32'(pc), 32'(exp_pc));
   endtask
   initial begin
      void'($urandom(32'hfd5c_0997));
      exp_pc = 13'h0000;
      for (int i = 0; i < 8; i++) stk[i] = 13'h0000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      axi_rd(PCS_OFF_PC_VALUE);
      check("pc view", rd, 32'h0000_0000);
      axi_rd(PCS_OFF_PC_HIGH_HOLDING_LATCH);
      check("latch reset", rd, 32'h0000_0000);
      $display("test reset done");
      // page bits set on purpose, they must not steer branches
      exp_latch = 5'($urandom) | 5'h18;
      axi_wr(PCS_OFF_PC_HIGH_HOLDING_LATCH, {27'h000_0000, exp_latch}, 4'hf);
      check("latch port", 32'(latch), 32'(exp_latch));
      check("latch write resp", 32'(resp), 32'(PCS_RESP_OKAY));
      for (int i = 0; i < 4; i++) begin
         b = 8'($urandom);
         axi_wr(PCS_OFF_PC_LOW_BYTE, {24'h00_0000, b}, (i == 3) ? 4'he : 4'hf);
         if (i != 3) exp_pc = {exp_latch, b};
         check("pc after low write", 32'(pc), 32'(exp_pc));
         axi_rd(PCS_OFF_PC_LOW_BYTE);
         check("low read", rd, {24'h00_0000, exp_pc[7:0]});
         check("low read resp", 32'(resp), 32'(PCS_RESP_OKAY));
      end
      axi_wr(8'h0c, 32'h0000_00aa, 4'hf);
      check("unmapped write", 32'(resp), 32'(PCS_RESP_SLVERR));
      axi_rd(8'h0c);
      check("unmapped read", 32'(resp), 32'(PCS_RESP_SLVERR));
      axi_wr(PCS_OFF_PC_VALUE, 32'h0000_1fff, 4'hf);
      check("pc view read only", 32'(pc), 32'(exp_pc));
      check("pc view write resp", 32'(resp), 32'(PCS_RESP_OKAY));
      $display("test registers done");
      step(PCS_OP_JUMP, 11'h0ff);
      step(PCS_OP_ADVANCE, 11'h000);
      step(PCS_OP_INT_ACK, 11'h000);
      step(PCS_OP_INTERRUPT_EXIT, 11'h000);
      // nine calls overrun eight entries, nine returns cycle all three forms
      for (int i = 0; i < 9; i++) step(PCS_OP_CALL, 11'($urandom));
      for (int i = 0; i < 9; i++) step(pcs_op_t'(3'(4 + i % 3)), 11'h000);
      check("latch kept", 32'(latch), 32'(exp_latch));
      $display("test stack done");
      // computed jump from the core: the low byte carries nothing upward
      @(posedge clk);
      lw <= 1'b1;
      ld <= 8'hff;
      @(posedge clk);
      lw <= 1'b0;
      exp_pc = {exp_latch, 8'hff};
      #1;
      check("computed jump", 32'(pc), 32'(exp_pc));
      $display("test computed jump done");
      give_verdict();
   end
   initial begin
      #100000;
      bad_count++;
      give_verdict();
   end
endmodule

// *** pcs_decoder_model.sv ***
// stand-in for the decoder and interrupt logic that drives the sequencer
`timescale 1ns/1ps
module pcs_decoder_model (
   input wire pcs_pkg::pcs_op_t op,
   input wire logic [pcs_pkg::PCS_TARGET_W-1:0] target,
   input wire logic low_wr,
   input wire logic [pcs_pkg::PCS_LOW_W-1:0] low_data,
   output pcs_pkg::pcs_cmd_t cmd,
   output pcs_pkg::pcs_low_wr_t core_low_wr
);
   import pcs_pkg::*;
   // page bits are written over the bus before any branch is issued
   assign cmd = '{op: op, target: target};
   // data is inverted while no write is made so a stale byte never passes; no carry expected
   assign core_low_wr = '{wr: low_wr, data: low_wr ? low_data : ~low_data};
endmodule

// *** pcs_pkg.sv ***
// shared constants, types and register map for the program counter and call stack
package pcs_pkg;
   // program counter and branch target geometry
   localparam int PCS_PC_W = 13;
   localparam int PCS_LOW_W = 8;
   localparam int PCS_HIGH_W = 5;
   localparam int PCS_TARGET_W = 11;
   localparam int PCS_PAGE_LSB = 3;
   localparam int PCS_PAGE_W = 2;
   localparam int PCS_STACK_DEPTH = 8;

   localparam logic [PCS_PC_W-1:0] PCS_PC_ONE = 13'h0001;
   localparam logic [PCS_PC_W-1:0] PCS_RESET_VECTOR = 13'h0000;
   localparam logic [PCS_PC_W-1:0] PCS_INT_VECTOR = 13'h0004;
   localparam logic [PCS_HIGH_W-1:0] PCS_LATCH_RESET = 5'h00;
   localparam logic [PCS_PAGE_W-1:0] PCS_PAGE_ZERO = 2'h0;

   // register byte addresses on the axi4-lite slave
   localparam int PCS_AXI_ADDR_W = 8;
   localparam logic [PCS_AXI_ADDR_W-1:0] PCS_OFF_PC_LOW_BYTE = 8'h00;
   localparam logic [PCS_AXI_ADDR_W-1:0] PCS_OFF_PC_HIGH_HOLDING_LATCH = 8'h04;
   localparam logic [PCS_AXI_ADDR_W-1:0] PCS_OFF_PC_VALUE = 8'h08;
   localparam logic [1:0] PCS_WORD_BITS = 2'h0;

   // axi response codes
   localparam logic [1:0] PCS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;
   localparam logic [31:0] PCS_DATA_ZERO = 32'h0000_0000;

   // sequencing command from the instruction decoder and interrupt logic
   typedef enum logic [2:0] {
      PCS_OP_HOLD = 3'b000,
      PCS_OP_ADVANCE = 3'b001,
      PCS_OP_JUMP = 3'b010,
      PCS_OP_CALL = 3'b011,
      PCS_OP_RETURN = 3'b100,
      PCS_OP_EXIT_WITH_LITERAL = 3'b101,
      PCS_OP_INTERRUPT_EXIT = 3'b110,
      PCS_OP_INT_ACK = 3'b111
   } pcs_op_t;

   typedef struct packed {
      pcs_op_t op;
      logic [PCS_TARGET_W-1:0] target;
   } pcs_cmd_t;

   // low byte write issued by the core datapath, e.g. a computed jump
   typedef struct packed {
      logic wr;
      logic [PCS_LOW_W-1:0] data;
   } pcs_low_wr_t;
endpackage
